// [bench/testbench.sv]
// Purpose: Self-checking bench of the host port
// Assumes: Drive model answers on the cable
// Notes: Ultra and multiword, drives 0 and 1
`timescale 1ns/1ps
module testbench
  import udmah_pkg::*;
;
  logic clk, rstn, io_wr, bm_enable, bm_dir, tx_valid, tx_ready, rx_valid;
  logic rx_ready, bm_err_clr, bm_err, bm_active, drive_dma_request, go;
  logic channel_ready_pin, cable_data_bus_oe, host_dma_acknowledge_n;
  logic chip_select_0_n, chip_select_1_n, read_command_pin_n;
  logic write_command_pin_n;
  logic [1:0] drive_sel, mode;
  logic [2:0] register_address_lines;
  logic [7:0] io_addr;
  logic [15:0] tx_data, rx_data, cable_data_bus_in, cable_data_bus_out;
  logic [15:0] exp_crc, drv_crc, drv_got;
  logic [31:0] io_wdata, io_rdata;
  logic [15:0] tx_words [4];
  int bad_count, n_tests, tx_i, rx_n;
  udmah_port dut (.clk, .rstn, .io_addr, .io_wr, .io_wdata, .io_rdata,
    .bm_enable, .bm_dir, .drive_sel, .tx_valid, .tx_data, .tx_ready,
    .rx_data, .rx_valid, .rx_ready, .bm_err_clr, .bm_err, .bm_active,
    .drive_dma_request, .channel_ready_pin, .cable_data_bus_in,
    .cable_data_bus_out, .cable_data_bus_oe, .host_dma_acknowledge_n,
    .chip_select_0_n, .chip_select_1_n, .register_address_lines,
    .read_command_pin_n, .write_command_pin_n);
  udmah_drive_model drv (.go, .mode, .dack_n(host_dma_acknowledge_n),
    .ior_n(read_command_pin_n), .iow_n(write_command_pin_n),
    .dout(cable_data_bus_out), .drq(drive_dma_request),
    .rdy(channel_ready_pin), .din(cable_data_bus_in), .crc(drv_crc),
    .got(drv_got));
  // Bus master side feeds and takes words
  assign tx_data = tx_words[tx_i[1:0]];
  assign tx_valid = bm_enable && tx_i < 4;
  always @(posedge clk) begin
    if (tx_ready) tx_i <= tx_i + 1;
    if (rx_valid) rx_n <= rx_n + 1;
    if (rx_valid) check(rx_data, 16'h1234 + 16'(rx_n) * 16'h1111);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    io_addr = a;
    @(negedge clk);
    check(io_rdata, exp);
  endtask : reg_rd
  // One burst, bounded waits on the active flag
  task automatic burst(input logic dir, input logic [1:0] md);
    @(negedge clk);
    bm_dir = dir;
    bm_enable = 1'b1;
    tx_i = 0;
    rx_n = 0;
    mode = md;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int c = 0; c < 20 && bm_active !== 1'b1; c++) @(negedge clk);
    for (int c = 0; c < 600 && bm_active !== 1'b0; c++) @(negedge clk);
    check(bm_active, 1'b0);
    bm_enable = 1'b0;
  endtask : burst
  task automatic t_regs();
    reg_rd(OFF_C0D0, 32'h00077771);
    reg_rd(OFF_C0D1, 32'h00017771);
    reg_rd(OFF_C1D0, 32'h00017771);
    reg_rd(OFF_C1D1, 32'h00017771);
    reg_wr(OFF_C0D0, 32'hffffffff);
    reg_wr(OFF_C0D1, 32'h7fffffff);
    reg_rd(OFF_C0D0, 32'h801fffff);
    reg_rd(OFF_C0D1, 32'h801fffff);
    reg_wr(8'h28, 32'hffffffff);
    reg_rd(8'h28, 32'h00000000);
    reg_wr(OFF_C0D0, 32'h00911030);
    reg_rd(OFF_C0D1, 32'h001fffff);
  endtask : t_regs
  task automatic t_write();
    tx_words = '{16'hffff, 16'h0000, 16'ha5a5, 16'h8001};
    exp_crc = CRC_SEED;
    foreach (tx_words[i]) exp_crc = drv.crc_step(exp_crc, tx_words[i]);
    burst(1'b0, 2'd0);
    check(tx_i, 4);
    check(drv_crc, exp_crc);
    check(drv_got, exp_crc);
    check(bm_err, 1'b0);
    reg_wr(OFF_C0D0, 32'h00077771);
    burst(1'b0, 2'd0);
    check(drv_crc, exp_crc);
    reg_wr(OFF_C0D0, 32'h00911030);
  endtask : t_write
  task automatic t_read();
    exp_crc = CRC_SEED;
    for (int k = 0; k < 4; k++) begin
      exp_crc = drv.crc_step(exp_crc, 16'h1234 + 16'(k) * 16'h1111);
    end
    burst(1'b1, 2'd1);
    check(rx_n, 4);
    check(drv_got, exp_crc);
  endtask : t_read
  task automatic t_abort();
    drive_sel = 2'd1; // Drive 1: long select setup
    burst(1'b0, 2'd2);
    check(bm_err, 1'b1);
    bm_err_clr = 1'b1;
    @(negedge clk);
    bm_err_clr = 1'b0;
    @(negedge clk);
    check(bm_err, 1'b0);
  endtask : t_abort
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    io_wr = 1'b0;
    io_addr = 8'h00;
    io_wdata = 32'h0;
    bm_enable = 1'b0;
    bm_dir = 1'b0;
    drive_sel = 2'd0;
    rx_ready = 1'b1;
    bm_err_clr = 1'b0;
    go = 1'b0;
    mode = 2'd0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_regs();
    t_write();
    t_read();
    t_abort();
    wrap_up();
  end
endmodule : testbench
bind udmah_port udmah_checker chk (.clk, .rstn, .bm_err, .bm_err_clr,
  .bm_active, .tx_ready, .rx_valid, .cable_data_bus_oe,
  .host_dma_acknowledge_n, .chip_select_0_n, .chip_select_1_n,
  .register_address_lines, .read_command_pin_n, .write_command_pin_n);

// [bench/udmah_checker.sv]
// Purpose: Pin level checks of the host port
// Assumes: One clock domain, async low reset
// Notes: Bound from the testbench file
`timescale 1ns/1ps
module udmah_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic bm_err,
  input wire logic bm_err_clr,
  input wire logic bm_active,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic cable_data_bus_oe,
  input wire logic host_dma_acknowledge_n,
  input wire logic chip_select_0_n,
  input wire logic chip_select_1_n,
  input wire logic [2:0] register_address_lines,
  input wire logic read_command_pin_n,
  input wire logic write_command_pin_n
);
  // ----
  // Clocking
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Cable let go soon after acknowledge ends
  sequence s_release;
    ##[1:2] (chip_select_0_n && !cable_data_bus_oe);
  endsequence
  a_addr_low: assert property (register_address_lines == 3'h0)
    else $error("address lines not low");
  a_ack_selects: assert property (
    !host_dma_acknowledge_n |-> !chip_select_0_n && !chip_select_1_n)
    else $error("select off during ack");
  a_ack_burst: assert property (
    $fell(host_dma_acknowledge_n) |-> bm_active) else $error("ack idle");
  a_cmd_idle: assert property (
    host_dma_acknowledge_n |-> read_command_pin_n && write_command_pin_n)
    else $error("command pin low without ack");
  a_ack_release: assert property (
    $rose(host_dma_acknowledge_n) |-> s_release) else $error("no release");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("rx pulse too long");
  a_err_hold: assert property (bm_err && !bm_err_clr |=> bm_err)
    else $error("error flag lost");
  a_tx_in_ack: assert property (
    tx_ready |-> bm_active && !host_dma_acknowledge_n) else $error("tx early");
  a_oe_select: assert property (
    cable_data_bus_oe |-> !chip_select_0_n) else $error("bus driven idle");
endmodule : udmah_checker

// [bench/udmah_drive_model.sv]
// Purpose: Behavioural drive on the cable
// Assumes: Strobe edges 100 ns apart, four words a burst
// Notes: Mode 0 receive, 1 send, 2 withdraw request early
`timescale 1ns/1ps
module udmah_drive_model
  import udmah_pkg::*;
(
  input wire logic go,
  input wire logic [1:0] mode,
  input wire logic dack_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [15:0] dout,
  output logic drq,
  output logic rdy,
  output logic [15:0] din,
  output logic [15:0] crc,
  output logic [15:0] got
);
  // Checksum step, whole word, high bit first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
    input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc_step
  initial begin
    drq = 1'b0;
    rdy = 1'b1;
    din = 16'h0000;
  end
  // One burst per go pulse
  always @(posedge go) begin
    crc = CRC_SEED;
    drq = 1'b1;
    if (mode == 2'd2) begin
      #200 drq = 1'b0; // Gone before acknowledge
    end else begin
      wait (!dack_n && !iow_n);
      #12.5; // Off the clock edge
      if (mode == 2'd1) begin
        wait (!ior_n);
        for (int k = 0; k < 4; k++) begin
          din = 16'h1234 + 16'(k) * 16'h1111;
          crc = crc_step(crc, din);
          #25 rdy = ~rdy;
          #75;
        end
        din = ~din; // Bus released, old value gone
      end else begin
        #100 rdy = 1'b0;
        repeat (4) begin
          @(ior_n or posedge iow_n); // Or multiword pulse
          crc = crc_step(crc, dout);
        end
        #112.5 rdy = 1'b1;
      end
      #100 drq = 1'b0;
      wait (iow_n);
      rdy = 1'b1;
    end
  end
  always @(posedge dack_n) got <= dout;
endmodule : udmah_drive_model

// [hdl/udmah_crc.sv]
// Purpose: Burst checksum over 16-bit words
// Assumes: One word per enable pulse
// Notes: Whole word folded in one cycle, high bit first

`timescale 1ns/1ps

module udmah_crc
  import udmah_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  udmah_link_if.crc lnk
);

  logic [15:0] crc_r; // Running value
  logic [15:0] crc_nxt; // Next value

  // One word step of the generator
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [15:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction : crc_step

  // ----------------------------------------------------------------
  // Seed at burst start, fold each valid word
  // ----------------------------------------------------------------
  always_comb begin
    crc_nxt = crc_r;
    if (lnk.crc_init) begin
      crc_nxt = CRC_SEED; // [R26]
    end else if (lnk.crc_en) begin
      crc_nxt = crc_step(crc_r, lnk.crc_word); // [R16] [R26]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_r <= CRC_SEED;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign lnk.crc_val = crc_r;

endmodule : udmah_crc

// [hdl/udmah_link_if.sv]
// Purpose: Carrier between the sequencer, timing registers and checksum
// Assumes: One clock domain
// Notes: Register access and checksum signals travel together

`timescale 1ns/1ps

interface udmah_link_if;
  logic [7:0] io_addr; // Register offset
  logic io_wr; // Write strobe
  logic [31:0] io_wdata; // Write data
  logic [31:0] io_rdata; // Registered read data
  logic [1:0] drive_sel; // Drive whose timing is used
  logic [31:0] timing; // Selected timing word
  logic udma_mode; // Global mode bit
  logic crc_init; // Reseed pulse
  logic crc_en; // Word strobe
  logic [15:0] crc_word; // Word to fold in
  logic [15:0] crc_val; // Running checksum

  modport core (output io_addr, io_wr, io_wdata, drive_sel, crc_init,
    crc_en, crc_word, input io_rdata, timing, udma_mode, crc_val);
  modport regs (input io_addr, io_wr, io_wdata, drive_sel,
    output io_rdata, timing, udma_mode);
  modport crc (input crc_init, crc_en, crc_word, output crc_val);
endinterface : udmah_link_if

// [hdl/udmah_pkg.sv]
// Purpose: Shared constants and types of the Ultra DMA host port
// Assumes: Timing fields are counted in cycles of the core clock
// Notes: Register offsets are byte addresses of the IDE I/O window

package udmah_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_C0D0 = 8'h24; // Channel 0 drive 0 timing
  localparam logic [7:0] OFF_C0D1 = 8'h2c; // Channel 0 drive 1 timing
  localparam logic [7:0] OFF_C1D0 = 8'h34; // Channel 1 drive 0 timing
  localparam logic [7:0] OFF_C1D1 = 8'h3c; // Channel 1 drive 1 timing

  localparam logic [31:0] RST_C0D0 = 32'h00077771; // Reset, first reg
  localparam logic [31:0] RST_OTHER = 32'h00017771; // Reset, the rest

  // Writable bits: reserved 30:21 always read zero
  localparam logic [31:0] WMASK_C0D0 = 32'h801fffff;
  localparam logic [31:0] WMASK_OTHER = 32'h001fffff;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int PIO_FMT_BIT = 31; // PIO timing format select
  localparam int MODE_BIT = 20; // 0 multiword, 1 ultra DMA
  localparam int MW_RD_REC_LSB = 16; // Read recovery
  localparam int MW_RD_PW_LSB = 12; // Read pulse width
  localparam int MW_WR_REC_LSB = 8; // Write recovery
  localparam int MW_WR_PW_LSB = 4; // Write pulse width
  localparam int SEL_SETUP_LSB = 0; // Select setup, both modes
  localparam int U_CRC_LSB = 16; // Checksum setup
  localparam int U_OUT_LSB = 12; // Output setup
  localparam int U_CYC_LSB = 8; // Data setup and cycle time
  localparam int U_PAUSE_LSB = 4; // Ready to pause

  // --------------------------------------------------------------
  // Timing adders and checksum
  // --------------------------------------------------------------
  localparam logic [4:0] ADD_ONE = 5'h01; // Field plus one cycle
  localparam logic [4:0] ADD_TWO = 5'h02; // Field plus two cycles
  localparam logic [15:0] CRC_POLY = 16'h1021; // x^16+x^12+x^5+1
  localparam logic [15:0] CRC_SEED = 16'h4aba; // Seed per burst

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_SEND, S_RECV, S_PAUSE, S_STOP, S_STB_HI,
    S_CRC_SET, S_CRC_OUT, S_MW_PULSE, S_MW_ACT, S_MW_REC
  } udmah_state_t;

  typedef struct packed {
    logic [31:0] tim0; // Timing registers
    logic [31:0] tim1;
    logic [31:0] tim2;
    logic [31:0] tim3;
    logic [31:0] rdata; // Registered read data
  } udmah_regs_t;

  typedef struct packed {
    udmah_state_t st; // Burst sequencer
    logic [4:0] cnt; // Interval counter
    logic udma; // Mode latched at burst start
    logic dir; // 1: data comes from drive
    logic pend; // Word on bus, strobe edge due
    logic dreq_m; // Synchroniser stages
    logic dreq_s;
    logic rdy_m;
    logic rdy_s;
    logic rdy_q; // Last synced ready level
    logic [15:0] din_m;
    logic [15:0] din_s;
    logic dack_n; // Cable outputs
    logic cs_n;
    logic ior_n;
    logic iow_n;
    logic [15:0] dout;
    logic doe;
    logic [15:0] rx_data; // Bus master side
    logic rx_valid;
    logic err;
  } udmah_core_t;

endpackage : udmah_pkg

// [hdl/udmah_port.sv]
// Purpose: Ultra DMA and multiword DMA host port of one IDE cable
// Assumes: Drive obeys its side of the burst handshake
// Notes: Cable inputs pass two flip-flops before use
//
// Operation
// [R01] Write command pin is STOP both ways
// [R02] Read command pin: host ready or strobe
// [R03] Ready pin: drive strobe or drive ready
// [R04] Other cable pins keep ordinary meaning
// [R05] Acknowledge with selects asserted, address low
// [R06] Write start: STOP off, wait drive ready
// [R07] Read start: STOP off, host ready on
// [R08] Receiver captures data on both strobe edges
// [R09] Sender pauses by holding strobe steady
// [R10] Receiver pauses by negating ready
// [R11] Burst ends only after being paused
// [R12] Host ends: STOP, drive drops request
// [R13] Drive ends: request drops, host STOPs
// [R14] Sender parks strobe high after stopping
// [R15] Checksum on bus while acknowledge rises
// [R16] Checksum covers valid strobed words only
// [R17] Drive compares checksums, reports mismatch
// [R18] Mode bit of first register picks mode
// [R19] Multiword fields: recoveries, pulses, select setup
// [R20] Ultra fields: checksum, setup, cycle, pause
// [R21] Format bit writable in first register only
// [R22] Multiword recommended values are software hints
// [R23] Ultra recommended values are software hints
// [R24] Direction bit picks transfer direction
// [R25] Transfer errors set sticky error flag
// [R26] Checksum generator and seed per burst
// [R27] Intervals counted in core clock cycles

`timescale 1ns/1ps

module udmah_port
  import udmah_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic [31:0] io_wdata,
  output logic [31:0] io_rdata,
  // Bus master side
  input wire logic bm_enable,
  input wire logic bm_dir,
  input wire logic [1:0] drive_sel,
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  output logic tx_ready,
  output logic [15:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic bm_err_clr,
  output logic bm_err,
  output logic bm_active,
  // Cable side
  input wire logic drive_dma_request,
  input wire logic channel_ready_pin,
  input wire logic [15:0] cable_data_bus_in,
  output logic [15:0] cable_data_bus_out,
  output logic cable_data_bus_oe,
  output logic host_dma_acknowledge_n,
  output logic chip_select_0_n,
  output logic chip_select_1_n,
  output logic [2:0] register_address_lines,
  output logic read_command_pin_n,
  output logic write_command_pin_n
);

  udmah_link_if lnk (); // Carrier to the helpers
  udmah_core_t s_r; // Registered state
  udmah_core_t s_nxt; // Next state
  logic done; // Interval expired
  logic edge_seen; // Synced ready pin changed
  logic take; // Capture a word from the drive
  logic crc_init; // Reseed checksum
  logic crc_en; // Fold a word
  logic [15:0] crc_word; // Word to fold
  logic set_err; // Error event this cycle

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  udmah_regs u_regs (.clk(clk), .rstn(rstn), .lnk(lnk.regs));
  udmah_crc u_crc (.clk(clk), .rstn(rstn), .lnk(lnk.crc));

  assign lnk.io_addr = io_addr;
  assign lnk.io_wr = io_wr;
  assign lnk.io_wdata = io_wdata;
  assign lnk.drive_sel = drive_sel;
  assign lnk.crc_init = crc_init;
  assign lnk.crc_en = crc_en;
  assign lnk.crc_word = crc_word;
  assign io_rdata = lnk.io_rdata;

  // Load value for a timing field plus its fixed adder
  function automatic logic [4:0] ld(input logic [31:0] t, input int lsb,
                                    input logic [4:0] add);
    ld = {1'b0, t[lsb +: 4]} + add; // [R19] [R20] [R27]
  endfunction : ld

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    tx_ready = 1'b0;
    crc_init = 1'b0;
    crc_en = 1'b0;
    crc_word = s_r.din_s;
    set_err = 1'b0;
    take = 1'b0;
    s_nxt.rx_valid = 1'b0;
    // Synchronisers: first stage read only by second
    s_nxt.dreq_m = drive_dma_request;
    s_nxt.dreq_s = s_r.dreq_m;
    s_nxt.rdy_m = channel_ready_pin;
    s_nxt.rdy_s = s_r.rdy_m;
    s_nxt.rdy_q = s_r.rdy_s;
    s_nxt.din_m = cable_data_bus_in;
    s_nxt.din_s = s_r.din_m;
    done = (s_r.cnt == 5'h00);
    edge_seen = (s_r.rdy_s != s_r.rdy_q);
    if (!done) begin
      s_nxt.cnt = s_r.cnt - 5'h01; // [R27]
    end
    case (s_r.st)
      S_IDLE: begin
        // Drive requests, host answers when the master is enabled
        if (bm_enable && s_r.dreq_s) begin
          s_nxt.st = S_SETUP;
          s_nxt.cs_n = 1'b0; // [R05]
          s_nxt.dir = bm_dir; // [R24]
          s_nxt.udma = lnk.udma_mode; // [R18]
          s_nxt.cnt = ld(lnk.timing, SEL_SETUP_LSB, ADD_ONE);
          crc_init = 1'b1; // [R26]
        end
      end
      S_SETUP: begin
        // Request withdrawn before acknowledge is a protocol fault
        if (!s_r.dreq_s) begin
          set_err = 1'b1; // [R25]
          s_nxt.cs_n = 1'b1;
          s_nxt.st = S_IDLE;
        end else if (done) begin
          s_nxt.dack_n = 1'b0; // [R05]
          if (!s_r.udma) begin
            s_nxt.st = S_MW_PULSE;
          end else if (s_r.dir) begin
            s_nxt.iow_n = 1'b0; // [R01] [R07]
            s_nxt.ior_n = !rx_ready; // [R02] [R07]
            s_nxt.st = S_RECV;
          end else begin
            s_nxt.iow_n = 1'b0; // [R01] [R06]
            s_nxt.ior_n = 1'b1;
            s_nxt.pend = 1'b0;
            s_nxt.st = S_SEND;
          end
        end
      end
      S_SEND: begin
        // Host is sender; strobe is the read command pin
        if (s_r.pend) begin
          if (done) begin
            s_nxt.ior_n = !s_r.ior_n; // [R02] [R08]
            s_nxt.pend = 1'b0;
            s_nxt.cnt = ld(lnk.timing, U_CYC_LSB, ADD_TWO);
          end
        end else if (!s_r.dreq_s) begin
          s_nxt.iow_n = 1'b1; // [R13] [R11]
          s_nxt.st = S_STB_HI;
        end else if (!bm_enable) begin
          s_nxt.iow_n = 1'b1; // [R12] [R11]
          s_nxt.st = S_STOP;
        end else if (done && !s_r.rdy_s && tx_valid) begin
          // Drive ready low means it accepts; else strobe held
          tx_ready = 1'b1; // [R03] [R06] [R09]
          s_nxt.dout = tx_data;
          s_nxt.doe = 1'b1;
          crc_en = 1'b1; // [R16]
          crc_word = tx_data;
          s_nxt.pend = 1'b1;
          s_nxt.cnt = ld(lnk.timing, U_OUT_LSB, ADD_ONE);
        end
      end
      S_RECV: begin
        // Host is receiver; ready follows bus master space
        s_nxt.ior_n = !rx_ready; // [R10]
        if (!s_r.dreq_s) begin
          s_nxt.iow_n = 1'b1; // [R13]
          s_nxt.ior_n = 1'b1;
          s_nxt.st = S_STB_HI;
        end else if (!bm_enable) begin
          s_nxt.ior_n = 1'b1; // [R10] [R11]
          s_nxt.cnt = ld(lnk.timing, U_PAUSE_LSB, ADD_ONE);
          s_nxt.st = S_PAUSE;
        end
      end
      S_PAUSE: begin
        // Drive may still strobe words until the pause settles
        if (!s_r.dreq_s) begin
          s_nxt.iow_n = 1'b1; // [R13]
          s_nxt.st = S_STB_HI;
        end else if (done) begin
          s_nxt.iow_n = 1'b1; // [R12]
          s_nxt.st = S_STOP;
        end
      end
      S_STOP: begin
        // Wait for the drive to drop its request
        if (!s_r.dreq_s) begin
          s_nxt.st = S_STB_HI; // [R12]
        end
      end
      S_STB_HI: begin
        // Sender parks strobe high before the checksum
        if (!s_r.dir) begin
          s_nxt.ior_n = 1'b1; // [R14]
          s_nxt.cnt = ld(lnk.timing, U_CRC_LSB, ADD_ONE);
          s_nxt.st = S_CRC_SET;
        end else if (s_r.rdy_s && !edge_seen) begin
          s_nxt.cnt = ld(lnk.timing, U_CRC_LSB, ADD_ONE); // [R14]
          s_nxt.st = S_CRC_SET;
        end
      end
      S_CRC_SET: begin
        // Checksum set up on the bus, then acknowledge rises
        s_nxt.dout = lnk.crc_val; // [R15]
        s_nxt.doe = 1'b1;
        if (done) begin
          s_nxt.dack_n = 1'b1; // [R15]
          s_nxt.cnt = ADD_ONE;
          s_nxt.st = S_CRC_OUT;
        end
      end
      S_CRC_OUT: begin
        // Hold data past the acknowledge edge, then release
        if (done) begin
          s_nxt.doe = 1'b0;
          s_nxt.cs_n = 1'b1;
          s_nxt.iow_n = 1'b1;
          s_nxt.ior_n = 1'b1;
          s_nxt.st = S_IDLE;
        end
      end
      S_MW_PULSE: begin
        // Multiword: one command pulse per word while requested
        if (!s_r.dreq_s || !bm_enable) begin
          s_nxt.dack_n = 1'b1;
          s_nxt.cs_n = 1'b1;
          s_nxt.doe = 1'b0;
          s_nxt.st = S_IDLE;
        end else if (s_r.dir && rx_ready) begin
          s_nxt.ior_n = 1'b0; // [R04]
          s_nxt.cnt = ld(lnk.timing, MW_RD_PW_LSB, ADD_ONE); // [R19]
          s_nxt.st = S_MW_ACT;
        end else if (!s_r.dir && tx_valid) begin
          tx_ready = 1'b1;
          s_nxt.dout = tx_data;
          s_nxt.doe = 1'b1;
          s_nxt.iow_n = 1'b0; // [R04]
          s_nxt.cnt = ld(lnk.timing, MW_WR_PW_LSB, ADD_ONE); // [R19]
          s_nxt.st = S_MW_ACT;
        end
      end
      S_MW_ACT: begin
        // End of pulse: read word taken, recovery begins
        if (done) begin
          if (s_r.dir) begin
            take = 1'b1;
            s_nxt.ior_n = 1'b1;
            s_nxt.cnt = ld(lnk.timing, MW_RD_REC_LSB, ADD_ONE);
          end else begin
            s_nxt.iow_n = 1'b1;
            s_nxt.cnt = ld(lnk.timing, MW_WR_REC_LSB, ADD_ONE);
          end
          s_nxt.st = S_MW_REC;
        end
      end
      S_MW_REC: begin
        if (done) begin
          s_nxt.st = S_MW_PULSE;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
    // Drive strobe edges while acknowledged carry read words
    if (s_r.udma && s_r.dir && !s_r.dack_n && edge_seen &&
        (s_r.st == S_RECV || s_r.st == S_PAUSE ||
         s_r.st == S_STOP || s_r.st == S_STB_HI)) begin
      take = 1'b1; // [R03] [R08]
      crc_en = 1'b1; // [R16]
    end
    if (take) begin
      s_nxt.rx_data = s_r.din_s;
      s_nxt.rx_valid = 1'b1;
      // No buffer here: a word with no room is lost
      if (!rx_ready) begin
        set_err = 1'b1; // [R25]
      end
    end
    // Set wins over clear
    s_nxt.err = (s_r.err && !bm_err_clr) || set_err; // [R25]
  end

  // Register state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: S_IDLE, dack_n: 1'b1, cs_n: 1'b1, ior_n: 1'b1,
               iow_n: 1'b1, rdy_m: 1'b1, rdy_s: 1'b1, rdy_q: 1'b1,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cable_data_bus_out = s_r.dout;
  assign cable_data_bus_oe = s_r.doe;
  assign host_dma_acknowledge_n = s_r.dack_n;
  assign chip_select_0_n = s_r.cs_n; // [R05]
  assign chip_select_1_n = s_r.cs_n; // [R05]
  assign register_address_lines = 3'h0; // [R05]
  assign read_command_pin_n = s_r.ior_n;
  assign write_command_pin_n = s_r.iow_n; // [R01]
  assign rx_data = s_r.rx_data;
  assign rx_valid = s_r.rx_valid;
  assign bm_err = s_r.err;
  assign bm_active = (s_r.st != S_IDLE);

endmodule : udmah_port

// [hdl/udmah_regs.sv]
// Purpose: Four per-drive DMA timing registers
// Assumes: Read data appears one cycle after the address
// Notes: Unmapped offsets read as zero

`timescale 1ns/1ps

module udmah_regs
  import udmah_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  udmah_link_if.regs lnk
);

  udmah_regs_t s_r; // Register state
  udmah_regs_t s_nxt; // Next state
  logic [31:0] view [4]; // Values as software reads them

  // ----------------------------------------------------------------
  // Read view and selection
  // ----------------------------------------------------------------
  // Format bit of the other drives mirrors the first register
  always_comb begin
    view[0] = s_r.tim0;
    view[1] = {s_r.tim0[PIO_FMT_BIT], s_r.tim1[30:0]}; // [R21]
    view[2] = {s_r.tim0[PIO_FMT_BIT], s_r.tim2[30:0]}; // [R21]
    view[3] = {s_r.tim0[PIO_FMT_BIT], s_r.tim3[30:0]}; // [R21]
  end

  assign lnk.timing = view[lnk.drive_sel];
  assign lnk.udma_mode = s_r.tim0[MODE_BIT]; // [R18]
  assign lnk.io_rdata = s_r.rdata;

  // ----------------------------------------------------------------
  // Write and read decode
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (lnk.io_wr) begin
      case (lnk.io_addr)
        OFF_C0D0: s_nxt.tim0 = lnk.io_wdata & WMASK_C0D0;
        OFF_C0D1: s_nxt.tim1 = lnk.io_wdata & WMASK_OTHER; // [R21]
        OFF_C1D0: s_nxt.tim2 = lnk.io_wdata & WMASK_OTHER; // [R21]
        OFF_C1D1: s_nxt.tim3 = lnk.io_wdata & WMASK_OTHER; // [R21]
        default: ; // Unmapped writes dropped
      endcase
    end
    case (lnk.io_addr)
      OFF_C0D0: s_nxt.rdata = view[0];
      OFF_C0D1: s_nxt.rdata = view[1];
      OFF_C1D0: s_nxt.rdata = view[2];
      OFF_C1D1: s_nxt.rdata = view[3];
      default: s_nxt.rdata = 32'h00000000;
    endcase
  end

  // Register state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= {RST_C0D0, RST_OTHER, RST_OTHER, RST_OTHER, 32'h00000000};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : udmah_regs
